/* verilog/fan_pkg.sv */
// Constants and helpers shared by the fan commutation logic.
`default_nettype none
package fan_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CARRIER_HZ = 25_000;
	localparam int unsigned CARRIER_PERIOD_CYC = CLK_HZ / CARRIER_HZ;
	localparam int unsigned LOCK_DETECT_MS = 300;
	localparam int unsigned SHUTDOWN_MS = 4200;
	localparam int unsigned STOP_DELAY_MS = 25;
	localparam int unsigned LOCK_DETECT_CYC = LOCK_DETECT_MS * (CLK_HZ / 1000);
	localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_MS * (CLK_HZ / 1000);
	localparam int unsigned STOP_DELAY_CYC = STOP_DELAY_MS * (CLK_HZ / 1000);
	// Level codes are 1/64 V per step: the ramp spans 0.5 V to 3 V.
	localparam logic [7:0] RAMP_LO_CODE = 8'h20;
	localparam logic [7:0] RAMP_HI_CODE = 8'hC0;
	localparam int unsigned CNT_PER_CODE = CARRIER_PERIOD_CYC / (RAMP_HI_CODE - RAMP_LO_CODE);
	localparam logic [1:0] START_EDGES = 2'h2;
	localparam logic [1:0] CTRL_ADDR = 2'h0;
	localparam logic [1:0] STATUS_ADDR = 2'h1;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam int unsigned CTRL_EN_BIT = 0;
	typedef enum logic [1:0] {ST_START, ST_RUN, ST_LOCKED, ST_STOPPED} fan_state_t;

	// Carrier count from which drive is on for a given level code.
	function automatic logic [11:0] on_threshold(input logic [7:0] level);
		logic [11:0] diff;
		diff = 12'(level - RAMP_LO_CODE);
		if (level <= RAMP_LO_CODE) begin
			return 12'h000;
		end else if (level >= RAMP_HI_CODE) begin
			return 12'(CARRIER_PERIOD_CYC);
		end
		return 12'(diff * 12'(CNT_PER_CODE));
	endfunction : on_threshold
endpackage : fan_pkg
`default_nettype wire

/* verilog/pwm_if.sv */
// Link between the control logic and the duty carrier.
`timescale 1ns/100ps
`default_nettype none
interface pwm_if;
	logic [7:0] level;
	logic on;
	logic period_start;
	modport ctrl (output level, input on, input period_start);
	modport carrier (input level, output on, output period_start);
endinterface : pwm_if
`default_nettype wire

/* verilog/duty_carrier.sv */
// Carrier counter and ramp comparison giving the on-duty window.
`timescale 1ns/100ps
`default_nettype none
module duty_carrier (
	input wire logic clk_i,
	input wire logic rst_b_i,
	pwm_if.carrier pw
);
	logic [11:0] cnt_q;

	// The counter stands for the ramp: 25 counts make one level code.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 12'h000;
		end else if (cnt_q == 12'(fan_pkg::CARRIER_PERIOD_CYC - 1)) begin
			cnt_q <= 12'h000;
		end else begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pw.on <= 1'b0;
			pw.period_start <= 1'b0;
		end else begin
			pw.on <= cnt_q >= fan_pkg::on_threshold(pw.level);
			pw.period_start <= cnt_q == 12'h000;
		end
	end

	property p_carrier_wrap;
		@(posedge clk_i) disable iff (!rst_b_i)
		cnt_q == 12'(fan_pkg::CARRIER_PERIOD_CYC - 1) |=> cnt_q == 12'h000;
	endproperty
	a_carrier_wrap: assert property (p_carrier_wrap) else $error("carrier period wrong");

	property p_full_duty;
		@(posedge clk_i) disable iff (!rst_b_i)
		(pw.level <= fan_pkg::RAMP_LO_CODE) |=> pw.on;
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("low level not full duty");

	property p_zero_duty;
		@(posedge clk_i) disable iff (!rst_b_i)
		(pw.level >= fan_pkg::RAMP_HI_CODE) |=> !pw.on;
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("high level not zero duty");
endmodule : duty_carrier
`default_nettype wire

/* verilog/fan_commutation_ctrl.sv */
// Commutation, lock protection, speed control and current limit of the fan driver.
// Functional notes
// - Field below release point drives first coil high, second coil low and tach high.
// - Field above operate point drives first coil low, second coil high and tach low.
// - Drive stops once the rotor stays locked longer than the lock-detect interval.
// - After a lock shutdown the motor restarts once the shutdown interval has passed.
// - An internal carrier of about 25 kHz modulates the coil drive.
// - On-duty comes from comparing the speed level with a 0.5 V to 3 V ramp.
// - The minimum-speed level sets a floor under the on-duty.
// - A motor start runs at full duty regardless of speed level and floor.
// - An open or grounded speed input runs the motor at full speed.
// - A speed level above 3 V for about 25 ms stops the motor and disables lock protection.
// - A level back at or below the minimum-speed level starts the motor at once.
// - Current limiting acts whenever the sense voltage passes the limit threshold.
`timescale 1ns/100ps
`default_nettype none
module fan_commutation_ctrl #(
	parameter int unsigned LOCK_CYC = fan_pkg::LOCK_DETECT_CYC,
	parameter int unsigned SHUTDOWN_CYC = fan_pkg::SHUTDOWN_CYC,
	parameter int unsigned STOP_CYC = fan_pkg::STOP_DELAY_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hall_north_i,
	input wire logic hall_south_i,
	input wire logic climit_i,
	input wire logic [7:0] speed_level_i,
	input wire logic [7:0] min_speed_level_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic first_coil_output_o,
	output logic second_coil_output_o,
	output logic tach_output_o
);
	pwm_if pw ();
	fan_pkg::fan_state_t state_q, state_d;
	logic [1:0] north_sync_q, south_sync_q, climit_sync_q;
	logic pol_q, pol_prev_q, sens_edge;
	logic [31:0] cnt_q, stop_cnt_q;
	logic [1:0] edge_cnt_q;
	logic cl_hold_q;
	logic [7:0] ctrl_q;
	logic speed_high, stop_hit, drive;
	logic north, south;

	duty_carrier u_carrier (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pw(pw.carrier)
	);

	// Sensor comparator and current comparator come from the analog side.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			north_sync_q <= 2'h0;
			south_sync_q <= 2'h0;
			climit_sync_q <= 2'h0;
		end else begin
			north_sync_q <= {north_sync_q[0], hall_north_i};
			south_sync_q <= {south_sync_q[0], hall_south_i};
			climit_sync_q <= {climit_sync_q[0], climit_i};
		end
	end

	assign north = north_sync_q[1] && !south_sync_q[1];
	assign south = south_sync_q[1] && !north_sync_q[1];

	// Pole state with hysteresis: inside the band nothing changes.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pol_q <= 1'b1;
		end else if (north) begin
			pol_q <= 1'b1;
		end else if (south) begin
			pol_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pol_prev_q <= 1'b1;
		end else begin
			pol_prev_q <= pol_q;
		end
	end

	assign sens_edge = pol_q != pol_prev_q;

	// Speed level codes come from a converter on this clock, so no synchroniser.
	assign speed_high = speed_level_i > fan_pkg::RAMP_HI_CODE;
	assign stop_hit = speed_high && (stop_cnt_q >= STOP_CYC - 1);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stop_cnt_q <= 32'h0000_0000;
		end else if (!speed_high) begin
			stop_cnt_q <= 32'h0000_0000;
		end else if (stop_cnt_q < STOP_CYC - 1) begin
			stop_cnt_q <= stop_cnt_q + 32'h0000_0001;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			fan_pkg::ST_START: begin
				if (stop_hit) begin
					state_d = fan_pkg::ST_STOPPED;
				end else if (edge_cnt_q == fan_pkg::START_EDGES) begin
					state_d = fan_pkg::ST_RUN;
				end else if (!sens_edge && cnt_q >= LOCK_CYC - 1) begin
					state_d = fan_pkg::ST_LOCKED;
				end
			end
			fan_pkg::ST_RUN: begin
				if (stop_hit) begin
					state_d = fan_pkg::ST_STOPPED;
				end else if (!sens_edge && cnt_q >= LOCK_CYC - 1) begin
					state_d = fan_pkg::ST_LOCKED;
				end
			end
			fan_pkg::ST_LOCKED: begin
				if (stop_hit) begin
					state_d = fan_pkg::ST_STOPPED;
				end else if (cnt_q >= SHUTDOWN_CYC - 1) begin
					state_d = fan_pkg::ST_START;
				end
			end
			fan_pkg::ST_STOPPED: begin
				if (!speed_high && speed_level_i <= min_speed_level_i) begin
					state_d = fan_pkg::ST_START;
				end
			end
			default: begin
				state_d = fan_pkg::ST_START;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= fan_pkg::ST_START;
		end else begin
			state_q <= state_d;
		end
	end

	// One counter times both lock detection and shutdown; stopped holds it at zero.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 32'h0000_0000;
		end else if (state_d != state_q || state_q == fan_pkg::ST_STOPPED) begin
			cnt_q <= 32'h0000_0000;
		end else if (sens_edge && state_q != fan_pkg::ST_LOCKED) begin
			cnt_q <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			edge_cnt_q <= 2'h0;
		end else if (state_q != fan_pkg::ST_START) begin
			edge_cnt_q <= 2'h0;
		end else if (sens_edge && edge_cnt_q != fan_pkg::START_EDGES) begin
			edge_cnt_q <= edge_cnt_q + 2'h1;
		end
	end

	// A limit event in the cycle of a period start still wins, so drive stays off.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cl_hold_q <= 1'b0;
		end else if (climit_sync_q[1]) begin
			cl_hold_q <= 1'b1;
		end else if (pw.period_start) begin
			cl_hold_q <= 1'b0;
		end
	end

	// Start forces the lowest level code; otherwise the floor caps the level.
	always_comb begin
		if (state_q == fan_pkg::ST_START) begin
			pw.level = 8'h00;
		end else if (speed_level_i > min_speed_level_i) begin
			pw.level = min_speed_level_i;
		end else begin
			pw.level = speed_level_i;
		end
	end

	assign drive = ctrl_q[fan_pkg::CTRL_EN_BIT] && pw.on && !cl_hold_q && !climit_sync_q[1]
		&& (state_q == fan_pkg::ST_START || state_q == fan_pkg::ST_RUN);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			first_coil_output_o <= 1'b0;
			second_coil_output_o <= 1'b0;
			tach_output_o <= 1'b1;
		end else begin
			first_coil_output_o <= drive && pol_q;
			second_coil_output_o <= drive && !pol_q;
			tach_output_o <= pol_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= fan_pkg::CTRL_RESET;
		end else if (wr_i && addr_i == fan_pkg::CTRL_ADDR) begin
			ctrl_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i && addr_i == fan_pkg::CTRL_ADDR) begin
			rdata_o <= ctrl_q;
		end else if (rd_i && addr_i == fan_pkg::STATUS_ADDR) begin
			rdata_o <= {3'h0, speed_high, cl_hold_q, pol_q, state_q};
		end else begin
			rdata_o <= 8'h00;
		end
	end

	sequence s_north_held;
		north ##1 north;
	endsequence

	sequence s_south_held;
		south ##1 south;
	endsequence

	property p_north_out;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_north_held |=> tach_output_o && !second_coil_output_o;
	endproperty
	a_north_out: assert property (p_north_out) else $error("north pole outputs wrong");

	property p_south_out;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_south_held |=> !tach_output_o && !first_coil_output_o;
	endproperty
	a_south_out: assert property (p_south_out) else $error("south pole outputs wrong");

	property p_band_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!north && !south) |=> $stable(pol_q);
	endproperty
	a_band_hold: assert property (p_band_hold) else $error("pole changed inside band");

	property p_lock_enter;
		@(posedge clk_i) disable iff (!rst_b_i)
		((state_q == fan_pkg::ST_RUN
			|| (state_q == fan_pkg::ST_START && edge_cnt_q != fan_pkg::START_EDGES))
			&& !stop_hit && !sens_edge && cnt_q == LOCK_CYC - 1)
		|=> state_q == fan_pkg::ST_LOCKED;
	endproperty
	a_lock_enter: assert property (p_lock_enter) else $error("lock not detected");

	property p_restart;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == fan_pkg::ST_LOCKED && !stop_hit && cnt_q == SHUTDOWN_CYC - 1)
		|=> state_q == fan_pkg::ST_START;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart after shutdown");

	property p_locked_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == fan_pkg::ST_LOCKED) [*2] |-> !first_coil_output_o && !second_coil_output_o;
	endproperty
	a_locked_off: assert property (p_locked_off) else $error("coil driven while locked");

	property p_stop;
		@(posedge clk_i) disable iff (!rst_b_i)
		stop_hit ##1 (state_q == fan_pkg::ST_STOPPED) |=> !first_coil_output_o && !second_coil_output_o;
	endproperty
	a_stop: assert property (p_stop) else $error("motor not stopped");

	property p_quick_start;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == fan_pkg::ST_STOPPED && !speed_high && speed_level_i <= min_speed_level_i)
		|=> state_q == fan_pkg::ST_START;
	endproperty
	a_quick_start: assert property (p_quick_start) else $error("no quick start");

	property p_climit;
		@(posedge clk_i) disable iff (!rst_b_i)
		climit_sync_q[1] |=> cl_hold_q ##1 (!first_coil_output_o && !second_coil_output_o);
	endproperty
	a_climit: assert property (p_climit) else $error("current limit ignored");

	property p_cl_period;
		@(posedge clk_i) disable iff (!rst_b_i)
		(cl_hold_q && !pw.period_start) |=> cl_hold_q;
	endproperty
	a_cl_period: assert property (p_cl_period) else $error("limit released mid period");

	property p_start_full;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == fan_pkg::ST_START) |-> pw.level == 8'h00;
	endproperty
	a_start_full: assert property (p_start_full) else $error("start not at full duty");

	property p_floor;
		@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == fan_pkg::ST_RUN) |-> pw.level <= min_speed_level_i;
	endproperty
	a_floor: assert property (p_floor) else $error("duty below floor");
endmodule : fan_commutation_ctrl
`default_nettype wire

/* tb/fan_rotor_model.sv */
// Behavioural single-coil rotor with its two-threshold field sensor.
`timescale 1ns/100ps
`default_nettype none
module fan_rotor_model #(
	parameter int HALF = 500,
	parameter int GAP = 20
) (
	input wire logic clk_i,
	input wire logic spin_i,
	input wire logic drive_i,
	output logic hall_north_o,
	output logic hall_south_o
);
	int pos = GAP;
	logic pole = 1'b1;
	// The rotor only moves while the coil is driven, so a shut-off driver really stalls it.
	always @(posedge clk_i) begin
		if (spin_i && drive_i) begin
			pos <= (pos == HALF - 1) ? 0 : pos + 1;
			if (pos == HALF - 1) begin
				pole <= ~pole;
			end
		end
	end
	// Near zero field neither comparator trips, which exercises the hold band.
	assign hall_north_o = (pos >= GAP) && pole;
	assign hall_south_o = (pos >= GAP) && !pole;
endmodule : fan_rotor_model
`default_nettype wire

/* tb/single_coil_fan_commutation_control_tb.sv */
// Self-checking bench for the fan commutation, lock and speed logic.
`timescale 1ns/100ps
`default_nettype none
module single_coil_fan_commutation_control_tb;
	localparam int LOCK = 8000;
	localparam int SHUT = 10000;
	localparam int STOP = 50;
	localparam int PER = fan_pkg::CARRIER_PERIOD_CYC;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic climit_i = 1'b0;
	logic [7:0] speed_level_i = 8'hA0;
	logic [7:0] min_speed_level_i = 8'hFF;
	logic [1:0] addr_i = 2'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic spin = 1'b0;
	logic hall_n, hall_s, coil_a, coil_b, tach;
	logic [7:0] rdata_o;
	logic pole_exp = 1'b1;
	logic [1:0] hall_prev = 2'h0;
	int fail_count = 0;
	int tests_run = 0;
	int seed = 48673;
	int stable = 0;
	int sp_tab[6] = '{0, 64, 160, 112, 0, 176};
	int mn_tab[6] = '{255, 255, 255, 255, 255, 160};

	fan_commutation_ctrl #(.LOCK_CYC(LOCK), .SHUTDOWN_CYC(SHUT), .STOP_CYC(STOP)) dut_u (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .hall_north_i(hall_n), .hall_south_i(hall_s),
		.climit_i(climit_i), .speed_level_i(speed_level_i),
		.min_speed_level_i(min_speed_level_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_coil_output_o(coil_a),
		.second_coil_output_o(coil_b), .tach_output_o(tach));
	fan_rotor_model rotor_u (.clk_i(clk_i), .spin_i(spin), .drive_i(coil_a | coil_b),
		.hall_north_o(hall_n), .hall_south_o(hall_s));

	always #5 clk_i = ~clk_i;

	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t output %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic check_count(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("[ERR] %0t on count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : check_count
	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask : bus_rd
	task automatic measure(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (coil_a === 1'b1 || coil_b === 1'b1)
				c++;
		end
	endtask : measure
	// Bench model of the on-duty: the lower of the two level codes sets the ramp crossing.
	function automatic int on_exp(input int spd, input int mn);
		int lv;
		lv = (spd < mn) ? spd : mn;
		if (lv <= 32)
			return PER;
		if (lv >= 192)
			return 0;
		return PER - (lv - 32) * (PER / 160);
	endfunction : on_exp
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// Outputs are judged only once the field has been steady long enough to pass the sync.
	always @(negedge clk_i) begin
		if (!rst_b_i || {hall_n, hall_s} != hall_prev) begin
			stable = 0;
		end else if (stable < 8) begin
			stable++;
		end
		hall_prev = {hall_n, hall_s};
		if (stable == 8 && hall_n !== hall_s) begin
			pole_exp = hall_n;
		end
		if (stable == 8) begin
			check_bit(tach, pole_exp);
			if (coil_a === 1'b1 || coil_b === 1'b1) begin
				check_bit(coil_a, pole_exp);
				check_bit(coil_b, !pole_exp);
			end
		end
	end

	initial begin
		#900_000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		logic [7:0] d;
		int cnt;
		int c1;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		bus_rd(fan_pkg::CTRL_ADDR, d);
		check_byte(d, 8'h01);
		bus_rd(fan_pkg::STATUS_ADDR, d);
		check_byte(d, 8'h04);
		bus_wr(2'h3, 8'hFF);
		bus_rd(2'h2, d);
		check_byte(d, 8'h00);
		measure(1000, cnt);
		check_count(cnt, 1000, 1000);
		measure(LOCK - 1500, cnt);
		check_count(cnt, LOCK - 1500, LOCK - 1500);
		repeat (800) @(posedge clk_i);
		bus_rd(fan_pkg::STATUS_ADDR, d);
		check_byte(d, 8'h06);
		measure(SHUT - 1500, cnt);
		check_count(cnt, 0, 0);
		repeat (1500) @(posedge clk_i);
		measure(500, cnt);
		check_count(cnt, 500, 500);
		@(posedge clk_i);
		spin <= 1'b1;
		speed_level_i <= 8'h00;
		repeat (4000) @(posedge clk_i);
		// The random level stays low enough that the rotor still turns inside the lock time.
		sp_tab[4] = 33 + ($unsigned($random(seed)) % 140);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			speed_level_i <= 8'(sp_tab[i]);
			min_speed_level_i <= 8'(mn_tab[i]);
			repeat (4) @(posedge clk_i);
			measure(PER, cnt);
			c1 = on_exp(sp_tab[i], mn_tab[i]);
			check_count(cnt, c1 - 2, c1 + 2);
		end
		@(posedge clk_i);
		speed_level_i <= 8'h70;
		min_speed_level_i <= 8'hFF;
		repeat (PER) @(posedge clk_i);
		for (int k = 0; k < PER && (coil_a | coil_b) !== 1'b0; k++)
			@(negedge clk_i);
		for (int k = 0; k < PER && (coil_a | coil_b) !== 1'b1; k++)
			@(negedge clk_i);
		repeat (100) @(posedge clk_i);
		climit_i <= 1'b1;
		measure(10, c1);
		@(posedge clk_i);
		climit_i <= 1'b0;
		measure(3800, cnt);
		check_count(cnt + c1, 2, 12);
		measure(PER, cnt);
		check_count(cnt, PER / 2 - 2, PER / 2 + 2);
		bus_wr(fan_pkg::CTRL_ADDR, 8'h00);
		measure(200, cnt);
		check_count(cnt, 0, 0);
		bus_rd(fan_pkg::CTRL_ADDR, d);
		check_byte(d, 8'h00);
		bus_wr(fan_pkg::CTRL_ADDR, 8'h5B);
		bus_rd(fan_pkg::CTRL_ADDR, d);
		check_byte(d, 8'h5B);
		@(posedge clk_i);
		speed_level_i <= 8'hFF;
		repeat (30) @(posedge clk_i);
		speed_level_i <= 8'h00;
		repeat (STOP + 20) @(posedge clk_i);
		bus_rd(fan_pkg::STATUS_ADDR, d);
		check_byte(d & 8'h1B, 8'h01);
		@(posedge clk_i);
		speed_level_i <= 8'hFF;
		repeat (STOP + 20) @(posedge clk_i);
		bus_rd(fan_pkg::STATUS_ADDR, d);
		check_byte(d & 8'h1B, 8'h13);
		measure(2000, cnt);
		check_count(cnt, 0, 0);
		@(posedge clk_i);
		speed_level_i <= 8'h90;
		min_speed_level_i <= 8'hA0;
		repeat (5) @(posedge clk_i);
		measure(100, cnt);
		check_count(cnt, 100, 100);
		summarize();
	end
endmodule : single_coil_fan_commutation_control_tb
`default_nettype wire
